/* File: tbsq_sequencer.sv */
`timescale 1ns/1ps
`include "tbsq_regs.svh"
module tbsq_sequencer #(
  parameter int unsigned SS_CYC   = `TBSQ_SS_CYC,
  parameter int unsigned GOOD_CYC = `TBSQ_GOOD_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [2:0]  CHANNEL_ENABLE_INPUTS,
  input  wire logic [2:0]  FEEDBACK_ABOVE_UPPER,
  input  wire logic [2:0]  FEEDBACK_ABOVE_LOWER,
  input  wire logic [2:0]  CURRENT_TRIP,
  input  wire logic [2:0]  CURRENT_LIMIT,
  input  wire logic [2:0]  SKIP_REQUEST,
  input  wire logic        EXTERNAL_LOGIC_SUPPLY,
  input  wire logic        SUPPLY_ABOVE_STARTUP,
  input  wire logic        PUMPED_ABOVE_STARTUP,
  input  wire logic        SUPPLY_ABOVE_SHUTDOWN,
  input  wire logic        PUMPED_ABOVE_SHUTDOWN,
  input  wire logic        SUPPLY_ABOVE_WARNING,
  input  wire logic        THERMAL_SHUTDOWN,
  input  wire logic        BIAS_GOOD,
  input  wire logic        POWER_GOOD_FLAG_IN,
  output logic             POWER_GOOD_FLAG_OUT,
  output logic             POWER_GOOD_FLAG_OE_N,
  output logic [2:0]       SWITCH_ON,
  output logic             PUMP_ENABLE,
  output logic [2:0]       SOFT_START_ACTIVE,
  output logic [23:0]      REFERENCE_LEVELS
);
  import tbsq_pkg::*;
  localparam logic [8:0] PER_CYC   = 9'(`TBSQ_PERIOD_CYC);
  localparam logic [8:0] PHASE_CYC = 9'(`TBSQ_PHASE_CYC);
  localparam logic [31:0] GOOD_LEN = 32'(GOOD_CYC);
  // Two-stage synchronisers for every asynchronous comparator input
  localparam int SYNC_W = 26;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {CHANNEL_ENABLE_INPUTS, FEEDBACK_ABOVE_UPPER, FEEDBACK_ABOVE_LOWER,
                 CURRENT_TRIP, CURRENT_LIMIT, SKIP_REQUEST, EXTERNAL_LOGIC_SUPPLY,
                 SUPPLY_ABOVE_STARTUP, PUMPED_ABOVE_STARTUP, SUPPLY_ABOVE_SHUTDOWN,
                 PUMPED_ABOVE_SHUTDOWN, SUPPLY_ABOVE_WARNING, THERMAL_SHUTDOWN,
                 BIAS_GOOD};
      sync_b <= sync_a;
    end
  end
  logic [2:0] en_s, fb_up, fb_lo, trip_s, lim_s, skip_s;
  logic       ext_s, su_s, cpsu_s, sd_s, cpsd_s, warn_s, tsd_s, bias_s;
  assign {en_s, fb_up, fb_lo, trip_s, lim_s, skip_s, ext_s, su_s, cpsu_s,
          sd_s, cpsd_s, warn_s, tsd_s, bias_s} = sync_b;
  typedef struct packed {
    logic [8:0]  phase_cnt;
    logic [2:0]  cyc_start;
    logic        pump_on;
    logic        pumped_ok;
    tbsq_pg_e    pg;
    logic [31:0] good_cnt;
    logic        flag;
    logic [2:0]  en_seen;
    logic [2:0]  sw;
    logic [2:0]  ss;
    logic [23:0] refs;
  } tbsq_top_s;
  tbsq_top_s r, next_r;
  logic        supply_ok;
  logic        run_ok;
  logic [2:0]  ch_start;
  logic [2:0]  ch_sw;
  tbsq_ch_e    ch_st [3];
  tbsq_ref_t   ch_ref [3];
  logic [2:0]  qual_up;
  logic [2:0]  qual_lo;
  logic        any_en;
  logic        new_en;
  // Shutdown level follows logic-supply configuration
  always_comb begin
    supply_ok = ext_s ? cpsd_s : sd_s;
    run_ok = r.pumped_ok && supply_ok && bias_s && !tsd_s;
    any_en = |en_s;
    qual_up = fb_up | ~en_s;
    qual_lo = fb_lo | ~en_s;
    new_en = |(en_s & ~r.en_seen);
  end
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      tbsq_channel #(
        .SS_CYC        (SS_CYC)
      ) u_ch (
        .clk           (CORE_CLK),
        .rst           (RST),
        .run_ok        (run_ok),
        .enable        (en_s[gi]),
        .cycle_start   (r.cyc_start[gi]),
        .current_trip  (trip_s[gi]),
        .current_limit (lim_s[gi]),
        .skip_request  (skip_s[gi]),
        .state         (ch_st[gi]),
        .switch_on     (ch_sw[gi]),
        .reference     (ch_ref[gi]),
        .started       (ch_start[gi])
      );
    end
  endgenerate
  always_comb begin
    next_r = r;
    next_r.cyc_start = 3'b000;
    // One shared period counter, three taps a third apart
    if (r.phase_cnt >= PER_CYC - 9'h001) begin
      next_r.phase_cnt = 9'h000;
    end else begin
      next_r.phase_cnt = r.phase_cnt + 9'h001;
    end
    next_r.cyc_start[0] = (r.phase_cnt == 9'h000);
    next_r.cyc_start[1] = (r.phase_cnt == PHASE_CYC);
    next_r.cyc_start[2] = (r.phase_cnt == PHASE_CYC + PHASE_CYC);
    // Pump follows raw supply startup, soft start waits for pumped level
    if (su_s) begin
      next_r.pump_on = 1'b1;
    end else if (!supply_ok) begin
      next_r.pump_on = 1'b0;
    end
    if (r.pump_on && cpsu_s) begin
      next_r.pumped_ok = 1'b1;
    end else if (!r.pump_on || !supply_ok) begin
      next_r.pumped_ok = 1'b0;
    end
    next_r.en_seen = en_s;
    next_r.sw = ch_sw;
    for (int i = 0; i < 3; i++) begin
      next_r.ss[i] = (ch_st[i] == TBSQ_SOFT);
      next_r.refs[i*8 +: 8] = ch_ref[i];
    end
    case (r.pg)
      TBSQ_PG_LOW: begin
        next_r.flag = 1'b0;
        next_r.good_cnt = 32'h00000000;
        if (any_en && &qual_up && warn_s && run_ok) begin
          next_r.pg = TBSQ_PG_TIME;
        end
      end
      TBSQ_PG_TIME: begin
        next_r.good_cnt = r.good_cnt + 32'h00000001;
        if (!any_en || new_en || !warn_s || !run_ok || !(&qual_lo)) begin
          next_r.pg = TBSQ_PG_LOW;
        end else if (!(&qual_up) && r.good_cnt == 32'h00000000) begin
          next_r.pg = TBSQ_PG_LOW;
        end else if (r.good_cnt >= GOOD_LEN - 32'h00000001) begin
          if (&qual_lo) begin
            next_r.pg = TBSQ_PG_HIGH;
            next_r.flag = 1'b1;
          end
        end
      end
      TBSQ_PG_HIGH: begin
        // Switchers are not touched by the warning, only the flag drops
        if (!any_en) begin
          next_r.pg = TBSQ_PG_LOW;
          next_r.flag = 1'b0;
        end else if (new_en) begin
          next_r.pg = TBSQ_PG_LOW;
          next_r.flag = 1'b0;
        end else if (!(&qual_lo) || !warn_s || !run_ok) begin
          next_r.pg = TBSQ_PG_LOW;
          next_r.flag = 1'b0;
        end
      end
      default: begin
        next_r.pg = TBSQ_PG_LOW;
        next_r.flag = 1'b0;
      end
    endcase
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // Open drain: enable low drives the pin low while unqualified
  assign POWER_GOOD_FLAG_OUT  = 1'b0;
  assign POWER_GOOD_FLAG_OE_N = r.flag;
  assign SWITCH_ON         = r.sw;
  assign PUMP_ENABLE       = r.pump_on;
  assign SOFT_START_ACTIVE = r.ss;
  assign REFERENCE_LEVELS  = r.refs;
endmodule : tbsq_sequencer

/* File: tbsq_regs.svh */
`ifndef TBSQ_REGS_SVH
`define TBSQ_REGS_SVH
`define TBSQ_CLK_MHZ        100
`define TBSQ_FSW_KHZ        550
`define TBSQ_PERIOD_CYC     (`TBSQ_CLK_MHZ * 1000 / `TBSQ_FSW_KHZ)
`define TBSQ_PHASE_CYC      (`TBSQ_PERIOD_CYC / 3)
`define TBSQ_MIN_DUTY_PCT   5
`define TBSQ_MAX_DUTY_PCT   90
`define TBSQ_MIN_ON_CYC     ((`TBSQ_PERIOD_CYC * `TBSQ_MIN_DUTY_PCT + 99) / 100)
`define TBSQ_MAX_ON_CYC     (`TBSQ_PERIOD_CYC * `TBSQ_MAX_DUTY_PCT / 100)
`define TBSQ_SS_US          1250
`define TBSQ_SS_CYC         (`TBSQ_SS_US * `TBSQ_CLK_MHZ)
`define TBSQ_REF_FULL       8'hFF
`define TBSQ_CAP_NF         470
`define TBSQ_SCALE_MILLI    2131
`define TBSQ_GOOD_US        (`TBSQ_SCALE_MILLI * `TBSQ_CAP_NF / 10)
`define TBSQ_GOOD_CYC       (`TBSQ_GOOD_US * `TBSQ_CLK_MHZ)
`endif

/* File: tbsq_pkg.sv */
package tbsq_pkg;
  typedef enum logic [1:0] {TBSQ_OFF, TBSQ_SOFT, TBSQ_RUN} tbsq_ch_e;
  typedef enum logic [1:0] {TBSQ_PG_LOW, TBSQ_PG_TIME, TBSQ_PG_HIGH} tbsq_pg_e;
  typedef logic [7:0] tbsq_ref_t;
endpackage : tbsq_pkg

/* File: tbsq_channel.sv */
`timescale 1ns/1ps
`include "tbsq_regs.svh"
module tbsq_channel #(
  parameter int unsigned SS_CYC = `TBSQ_SS_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               run_ok,
  input  wire logic               enable,
  input  wire logic               cycle_start,
  input  wire logic               current_trip,
  input  wire logic               current_limit,
  input  wire logic               skip_request,
  output tbsq_pkg::tbsq_ch_e      state,
  output logic                    switch_on,
  output tbsq_pkg::tbsq_ref_t     reference,
  output logic                    started
);
  import tbsq_pkg::*;
  localparam logic [8:0]  PER_CYC = 9'(`TBSQ_PERIOD_CYC);
  localparam logic [8:0]  MIN_ON  = 9'(`TBSQ_MIN_ON_CYC);
  localparam logic [8:0]  MAX_ON  = 9'(`TBSQ_MAX_ON_CYC);
  localparam logic [23:0] SS_STEP = 24'(SS_CYC / 256);
  typedef struct packed {
    tbsq_ch_e   st;
    logic       sw;
    logic [8:0] on_cnt;
    logic [23:0] ss_cnt;
    tbsq_ref_t  ref_lvl;
    logic       en_d;
    logic       start;
  } tbsq_chs_s;
  tbsq_chs_s r, next_r;
  always_comb begin
    next_r = r;
    next_r.en_d = enable;
    next_r.start = 1'b0;
    if (r.sw) begin
      next_r.on_cnt = r.on_cnt + 9'h001;
    end
    case (r.st)
      TBSQ_OFF: begin
        next_r.sw = 1'b0;
        next_r.ref_lvl = 8'h00;
        if (enable && run_ok) begin
          next_r.st = TBSQ_SOFT;
          next_r.ss_cnt = 24'h000000;
          next_r.start = 1'b1;
        end
      end
      TBSQ_SOFT, TBSQ_RUN: begin
        if (r.st == TBSQ_SOFT) begin
          next_r.ss_cnt = r.ss_cnt + 24'h000001;
          // Step on the last count so a full ramp lasts SS_CYC cycles
          if (r.ss_cnt + 24'h000001 >= SS_STEP) begin
            next_r.ss_cnt = 24'h000000;
            if (r.ref_lvl == `TBSQ_REF_FULL) begin
              next_r.st = TBSQ_RUN;
            end else begin
              next_r.ref_lvl = r.ref_lvl + 8'h01;
            end
          end
        end
        // Feedback drops never re-enter soft start, only faults or disable
        if (cycle_start && !skip_request) begin
          next_r.sw = 1'b1;
          next_r.on_cnt = 9'h000;
        end else if (r.sw && (current_limit || r.on_cnt >= MAX_ON ||
                     (current_trip && r.on_cnt >= MIN_ON))) begin
          next_r.sw = 1'b0;
        end
        if (!enable || !run_ok) begin
          next_r.st = TBSQ_OFF;
          next_r.sw = 1'b0;
          next_r.ref_lvl = 8'h00;
        end
      end
      default: begin
        next_r.st = TBSQ_OFF;
      end
    endcase
    if (r.on_cnt > PER_CYC) begin
      next_r.on_cnt = PER_CYC;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign state     = r.st;
  assign switch_on = r.sw;
  assign reference = r.ref_lvl;
  assign started   = r.start;
endmodule : tbsq_channel

/* File: tbsq_sequencer_props.sv */
`timescale 1ns/1ps
module tbsq_sequencer_props #(
  parameter int unsigned SS_CYC   = 512,
  parameter int unsigned GOOD_CYC = 50
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic [2:0]  CHANNEL_ENABLE_INPUTS,
  input wire logic [2:0]  FEEDBACK_ABOVE_LOWER,
  input wire logic [2:0]  CURRENT_LIMIT,
  input wire logic        SUPPLY_ABOVE_STARTUP,
  input wire logic        SUPPLY_ABOVE_WARNING,
  input wire logic        THERMAL_SHUTDOWN,
  input wire logic        POWER_GOOD_FLAG_OUT,
  input wire logic        POWER_GOOD_FLAG_OE_N,
  input wire logic [2:0]  SWITCH_ON,
  input wire logic        PUMP_ENABLE,
  input wire logic [2:0]  SOFT_START_ACTIVE,
  input wire logic [23:0] REFERENCE_LEVELS
);
  typedef struct packed {
    logic [2:0]  ena;
    logic [31:0] qual;
    logic [7:0]  on;
  } tbsq_chk_s;
  localparam int MAX_ON = 162;
  tbsq_chk_s cur, next_cur;
  wire logic [2:0] ena = CHANNEL_ENABLE_INPUTS;
  always_comb begin
    next_cur = cur;
    next_cur.ena = ena;
    // Raw inputs lead the synced ones, so never shorter than the real timer
    if (ena == 3'h0 || (ena & ~cur.ena) != 3'h0 || (FEEDBACK_ABOVE_LOWER & ena) != ena) begin
      next_cur.qual = 32'h0;
    end else if (cur.qual != 32'hFFFFFFFF) begin
      next_cur.qual = cur.qual + 32'h1;
    end
    next_cur.on = !SWITCH_ON[0] ? 8'h0 : cur.on + {7'h0, cur.on != 8'hFF};
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) cur <= '0;
    else cur <= next_cur;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_all_off; (CHANNEL_ENABLE_INPUTS == 3'h0) [*5]; endsequence
  sequence s_warn_low; !SUPPLY_ABOVE_WARNING [*5]; endsequence
  sequence s_fb_drop; ((FEEDBACK_ABOVE_LOWER & ena) != ena) [*5]; endsequence
  a_drive_low: assert property (POWER_GOOD_FLAG_OUT == 1'b0)
    else $error("flag drive level not low");
  a_last_off: assert property (s_all_off |-> !POWER_GOOD_FLAG_OE_N)
    else $error("flag high with no channel on");
  a_warn_flag: assert property (s_warn_low |-> !POWER_GOOD_FLAG_OE_N)
    else $error("flag high under supply warning");
  a_drop_flag: assert property (s_fb_drop |-> !POWER_GOOD_FLAG_OE_N)
    else $error("flag high with feedback low");
  a_rise_delay: assert property ($rose(POWER_GOOD_FLAG_OE_N) |-> cur.qual >= GOOD_CYC)
    else $error("flag rose before delay");
  a_new_enable: assert property ((ena & ~$past(ena)) != 3'h0 |-> ##[1:5] !POWER_GOOD_FLAG_OE_N)
    else $error("flag held on new enable");
  a_pump_start: assert property ($rose(PUMP_ENABLE) |-> $past(SUPPLY_ABOVE_STARTUP, 3))
    else $error("pump on without supply");
  a_thermal_off: assert property (THERMAL_SHUTDOWN [*5] |-> SWITCH_ON == 3'h0)
    else $error("switching in thermal fault");
  // A cycle start may still open the switch for one cycle under limit
  a_limit_end: assert property (CURRENT_LIMIT[0] [*5] |-> !(SWITCH_ON[0] && $past(SWITCH_ON[0])))
    else $error("switch held on through limit");
  a_max_on: assert property (cur.on <= MAX_ON)
    else $error("on time too long");
  a_ref_ramp: assert property (SOFT_START_ACTIVE[0] && $past(SOFT_START_ACTIVE[0]) |->
    REFERENCE_LEVELS[7:0] >= $past(REFERENCE_LEVELS[7:0]))
    else $error("reference fell in soft start");
  a_soft_cause: assert property ($rose(SOFT_START_ACTIVE[0]) |->
    $past(ena[0], 4) && !$past(THERMAL_SHUTDOWN, 4))
    else $error("soft start without cause");
endmodule : tbsq_sequencer_props

/* File: tbsq_ctrl_model.sv */
`timescale 1ns/1ps
module tbsq_ctrl_model (
  input  wire logic       clk,
  input  wire logic [2:0] want,
  input  wire logic       restart,
  input  wire logic       flag_out,
  input  wire logic       flag_oe_n,
  output logic [2:0]      enable,
  output logic            good
);
  // Pull-up holds the released line high
  assign good = flag_oe_n ? 1'b1 : flag_out;
  initial enable = 3'h0;
  always @(negedge clk) begin
    // One cycle off is enough to force a fresh ramp
    enable <= restart ? 3'h0 : want;
  end
endmodule : tbsq_ctrl_model

/* File: tbsq_sequencer_test.sv */
`timescale 1ns/1ps
module tbsq_sequencer_test;
  localparam int SS = 512;
  localparam int GD = 50;
  typedef struct {int sel; logic [23:0] exp;} tbsq_note_s;
  logic clk, rst, ext, s_su, p_su, s_sd, p_sd, warn, therm, bias, restart, pg_out, pg_oe_n, pump, good;
  logic [2:0] want, fb_up, fb_lo, trip, lim, skip, en, sw, ss;
  logic [23:0] refs, cnt;
  int n_fail, checks, cyc, t, r0;
  int seed = 32'hD6BE8BC9;
  string nm[5] = '{"flag", "soft", "switch", "pump", "count"};
  tbsq_note_s q[$];
  tbsq_note_s nt;
  event chk;
  tbsq_sequencer #(.SS_CYC(SS), .GOOD_CYC(GD)) tbsq_sequencer_inst (
    .CORE_CLK(clk), .RST(rst), .CHANNEL_ENABLE_INPUTS(en), .FEEDBACK_ABOVE_UPPER(fb_up),
    .FEEDBACK_ABOVE_LOWER(fb_lo), .CURRENT_TRIP(trip), .CURRENT_LIMIT(lim), .SKIP_REQUEST(skip),
    .EXTERNAL_LOGIC_SUPPLY(ext), .SUPPLY_ABOVE_STARTUP(s_su), .PUMPED_ABOVE_STARTUP(p_su),
    .SUPPLY_ABOVE_SHUTDOWN(s_sd), .PUMPED_ABOVE_SHUTDOWN(p_sd), .SUPPLY_ABOVE_WARNING(warn),
    .THERMAL_SHUTDOWN(therm), .BIAS_GOOD(bias), .POWER_GOOD_FLAG_IN(good), .POWER_GOOD_FLAG_OUT(pg_out),
    .POWER_GOOD_FLAG_OE_N(pg_oe_n), .SWITCH_ON(sw), .PUMP_ENABLE(pump), .SOFT_START_ACTIVE(ss),
    .REFERENCE_LEVELS(refs));
  tbsq_ctrl_model tbsq_ctrl_model_inst (.clk(clk), .want(want), .restart(restart),
    .flag_out(pg_out), .flag_oe_n(pg_oe_n), .enable(en), .good(good));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test();
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [23:0] seen_of(input int s);
    case (s)
      0: return {23'h0, pg_oe_n};
      1: return {21'h0, ss};
      2: return {21'h0, sw};
      3: return {23'h0, pump};
      default: return cnt;
    endcase
  endfunction : seen_of
  task automatic note(input int s, input logic [23:0] v);
    q.push_back('{s, v});
    ->chk;
  endtask : note
  task automatic n(input int k);
    repeat (k) @(negedge clk);
  endtask : n
  always @(chk) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      check(nm[nt.sel], seen_of(nt.sel), nt.exp);
    end
  end
  // Ceiling well above the full sequence length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  always @(posedge sw[0]) r0++;
  always @(negedge clk) trip <= 3'($random(seed));
  initial begin
    {ext, s_su, p_su, s_sd, p_sd, warn, therm, bias, restart} = '0;
    {want, fb_up, fb_lo, lim, skip, trip} = '0;
    rst = 1'b1;
    cnt = '0;
    n(8);
    note(0, 0);
    rst = 1'b0;
    {ext, bias, s_su, s_sd, warn} = 5'h1F;
    want <= 3'h1;
    n(8); note(3, 1); note(1, 0);
    {p_su, p_sd} = 2'h3;
    n(8); note(1, 3'h1);
    n(SS + 40); note(0, 0);
    cnt = refs; note(4, 24'h0000FF);
    fb_up = 3'h1; fb_lo = 3'h1;
    n(GD - 5); note(0, 0);
    n(20); note(0, 1);
    want <= 3'h3;
    n(8); note(0, 0); note(1, 3'h2);
    n(SS + 40); note(0, 0);
    fb_up = 3'h3; fb_lo = 3'h3; // Settles before the delay can start
    n(GD + 20); note(0, 1);
    @(posedge sw[0]); t = cyc;
    @(posedge sw[1]); cnt = 24'(cyc - t);
    n(1); note(4, 60);
    lim = 3'h1; n(200); lim = 3'h0; // Spans a cycle start
    skip = 3'h1; n(5); r0 = 0;
    n(400); cnt = 24'(r0); note(4, 0);
    skip = 3'h0; n(5); r0 = 0;
    n(400); cnt = 24'(r0 > 0); note(4, 1);
    warn = 1'b0; r0 = 0;
    n(8); note(0, 0);
    n(300); cnt = 24'(r0 > 0); note(4, 1);
    warn = 1'b1;
    n(GD + 20); note(0, 1);
    fb_up = 3'h2; fb_lo = 3'h2;
    n(8); note(0, 0); note(1, 0);
    fb_up = 3'h3; fb_lo = 3'h3;
    n(GD + 20); note(0, 1);
    s_sd = 1'b0; r0 = 0;
    n(300); cnt = 24'(r0 > 0); note(4, 1);
    ext = 1'b0;
    n(8); note(2, 0);
    s_sd = 1'b1;
    n(10); note(1, 3'h3);
    n(SS + 40); therm = 1'b1;
    n(8); note(2, 0);
    therm = 1'b0;
    n(10); note(1, 3'h3);
    n(SS + 40); restart <= 1'b1;
    n(1); restart <= 1'b0;
    n(8); note(1, 3'h3);
    n(SS + GD + 40); note(0, 1);
    want <= 3'h0;
    n(6); note(0, 0);
    n(2);
    finish_test();
  end
endmodule : tbsq_sequencer_test
bind tbsq_sequencer tbsq_sequencer_props #(.SS_CYC(SS_CYC), .GOOD_CYC(GOOD_CYC)) tbsq_sequencer_props_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .CHANNEL_ENABLE_INPUTS(CHANNEL_ENABLE_INPUTS),
  .FEEDBACK_ABOVE_LOWER(FEEDBACK_ABOVE_LOWER), .CURRENT_LIMIT(CURRENT_LIMIT),
  .SUPPLY_ABOVE_STARTUP(SUPPLY_ABOVE_STARTUP), .SUPPLY_ABOVE_WARNING(SUPPLY_ABOVE_WARNING),
  .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .POWER_GOOD_FLAG_OUT(POWER_GOOD_FLAG_OUT),
  .POWER_GOOD_FLAG_OE_N(POWER_GOOD_FLAG_OE_N), .SWITCH_ON(SWITCH_ON), .PUMP_ENABLE(PUMP_ENABLE),
  .SOFT_START_ACTIVE(SOFT_START_ACTIVE), .REFERENCE_LEVELS(REFERENCE_LEVELS));
